// [hw/gauge_i2c_defines.svh]
// Constants of the two-wire target port of the battery monitor
// ==========================================================================
// Overview of operation
// - Answer only the fixed 7-bit target address 1010101.
// - First byte is 0xAA for write, 0xAB for read.
// - Support read, incremental read, quick read, single write, incremental write.
// - Quick read returns the byte at the current command pointer.
// - Pointer advances by one on every acknowledged data byte.
// - Data written to a read-only location is not acknowledged.
// - Command location above 0x6B is not acknowledged.
// - Bus held low for 2 seconds: release SDA and SCL.
// - Lines still held low after release: request low-power sleep.
// - Host polls standard commands at most twice per second.
// - Sleep and hibernate: stretch SCL at start of all traffic, up to 4 ms.
// - Normal modes: stretch only for packets carrying our own address.
// - Flow-control stretch after start, acknowledge or first bit, up to 4 ms; code stretches on any SCL fall from the address acknowledge on.
// - Non-volatile updates may stretch longer, up to 144 ms.
// - Two-byte commands occupy consecutive locations, both bytes accessed.
// - Write permission depends on sealed or unsealed access mode.
`ifndef GAUGE_I2C_DEFINES_SVH
`define GAUGE_I2C_DEFINES_SVH

// ==========================================================================
// Addressing
`define TARGET_ADDR 7'h55
`define WR_BYTE 8'hAA
`define RD_BYTE 8'hAB
`define CMD_MAX 8'h6B
`define BIT_LAST 3'h7
`define PTR_STEP 8'h01

// ==========================================================================
// Timing, core clock 10 MHz
`define CLK_HZ 32'h0098_9680
`define MS_PER_S 32'h0000_03E8
`define TIMEOUT_S 32'h0000_0002
`define WAKE_MS 32'h0000_0004
`define FLOW_MS 32'h0000_0004
`define NV_MAX_MS 32'h0000_0090
`define TIMEOUT_CYC (`TIMEOUT_S * `CLK_HZ)
`define WAKE_CYC (`WAKE_MS * `CLK_HZ / `MS_PER_S)
`define FLOW_CYC (`FLOW_MS * `CLK_HZ / `MS_PER_S)
`define NV_CYC (`NV_MAX_MS * `CLK_HZ / `MS_PER_S)
`define TMR_W 25

`endif

// [hw/gauge_i2c_pkg.sv]
// Types shared by the two-wire target port
`default_nettype none
package gauge_i2c_pkg;
  // Protocol engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_ACK_OUT, ST_ACK_IN, ST_IGNORE
  } state_t;
  // Device power modes
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_BATTERY_PRESENCE_WAIT, MODE_SNOOZE, MODE_SLEEP, MODE_HIBERNATE
  } mode_t;
endpackage
`default_nettype wire

// [hw/gauge_hold_timer.sv]
// Up-counter that saturates at a limit, used for hold and timeout intervals
`timescale 1ns/100ps
`default_nettype none
module gauge_hold_timer #(
  parameter int W = 25
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic [W-1:0] limit_in,
  output logic done_out
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Saturate so done stays high until cleared
  always_comb begin
    next_count = count;
    if (clear_in) begin
      next_count = '0;
    end else if (count < limit_in) begin
      next_count = count + {{(W-1){1'h0}}, 1'h1};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = !clear_in && (count >= limit_in);
endmodule
`default_nettype wire

// [hw/gauge_i2c_target.sv]
// Two-wire target port: protocol engine, stretching and stuck-bus timeout
`timescale 1ns/100ps
`default_nettype none
`include "gauge_i2c_defines.svh"
module gauge_i2c_target import gauge_i2c_pkg::*; #(
  parameter logic [`TMR_W-1:0] TIMEOUT_CYCLES = `TMR_W'(`TIMEOUT_CYC),
  parameter logic [`TMR_W-1:0] WAKE_CYCLES = `TMR_W'(`WAKE_CYC),
  parameter logic [`TMR_W-1:0] FLOW_CYCLES = `TMR_W'(`FLOW_CYC),
  parameter logic [`TMR_W-1:0] NV_CYCLES = `TMR_W'(`NV_CYC)
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  input wire mode_t power_mode_in,
  input wire logic sealed_in,
  input wire logic writable_sealed_in,
  input wire logic writable_unsealed_in,
  input wire logic core_busy_in,
  input wire logic nv_update_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] cmd_addr_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_en_out,
  output logic sleep_req_out
);
  // ========================================================================
  // Line edges and conditions
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start, stop, lines_high;
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign start = scl_in && scl_q && sda_q && !sda_in;
  assign stop = scl_in && scl_q && !sda_q && sda_in;
  assign lines_high = scl_in && sda_in;

  // ========================================================================
  // Protocol engine state
  state_t state, next_state, after, next_after;
  logic [7:0] shift, next_shift, pointer, next_pointer;
  logic [7:0] wr_addr, next_wr_addr, wr_data, next_wr_data;
  logic [2:0] cnt, next_cnt;
  logic full, next_full, acked, next_acked, sda_low, next_sda_low, wr_en, next_wr_en;
  logic writable, to_done;
  // Permission follows the access mode; table lookup stays in the core
  assign writable = sealed_in ? writable_sealed_in : writable_unsealed_in;

  // Byte receive, acknowledge and transmit sequencing
  always_comb begin
    next_state = state;
    next_after = after;
    next_shift = shift;
    next_pointer = pointer;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_cnt = cnt;
    next_full = full;
    next_acked = acked;
    next_sda_low = sda_low;
    next_wr_en = 1'h0;
    if (to_done) begin
      next_state = ST_IDLE;
      next_sda_low = 1'h0;
      next_full = 1'h0;
    end else if (start) begin
      next_state = ST_ADDR;
      next_cnt = 3'h0;
      next_full = 1'h0;
      next_sda_low = 1'h0;
    end else if (stop) begin
      next_state = ST_IDLE;
      next_sda_low = 1'h0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_in};
            next_cnt = cnt + 3'h1;
            next_full = (cnt == `BIT_LAST);
          end else if (scl_fall && full) begin
            next_full = 1'h0;
            next_cnt = 3'h0;
            next_state = ST_IGNORE;
            if (state == ST_ADDR) begin
              // Only the two combined address bytes are answered
              if (shift == `WR_BYTE || shift == `RD_BYTE) begin
                next_sda_low = 1'h1;
                next_state = ST_ACK_OUT;
                next_after = shift[0] ? ST_RDATA : ST_CMD;
              end
            end else if (state == ST_CMD) begin
              if (shift <= `CMD_MAX) begin
                next_pointer = shift;
                next_sda_low = 1'h1;
                next_state = ST_ACK_OUT;
                next_after = ST_WDATA;
              end
            end else if (writable) begin
              next_wr_en = 1'h1;
              next_wr_addr = pointer;
              next_wr_data = shift;
              next_pointer = pointer + `PTR_STEP;
              next_sda_low = 1'h1;
              next_state = ST_ACK_OUT;
              next_after = ST_WDATA;
            end
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            next_state = after;
            next_sda_low = 1'h0;
            if (after == ST_RDATA) begin
              // No command byte needed: data comes from the live pointer
              next_shift = rd_data_in;
              next_sda_low = !rd_data_in[7];
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt == `BIT_LAST) begin
              next_state = ST_ACK_IN;
              next_sda_low = 1'h0;
              next_cnt = 3'h0;
            end else begin
              next_shift = {shift[6:0], 1'h0};
              next_sda_low = !shift[6];
              next_cnt = cnt + 3'h1;
            end
          end
        end
        ST_ACK_IN: begin
          if (scl_rise) begin
            next_acked = !sda_in;
            if (!sda_in) begin
              next_pointer = pointer + `PTR_STEP;
            end
          end else if (scl_fall) begin
            // Pointer already moved, so read data is settled by now
            if (acked) begin
              next_state = ST_RDATA;
              next_shift = rd_data_in;
              next_sda_low = !rd_data_in[7];
            end else begin
              next_state = ST_IGNORE;
            end
          end
        end
        default: begin
          next_sda_low = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      shift <= 8'h00;
      pointer <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      cnt <= 3'h0;
      full <= 1'h0;
      acked <= 1'h0;
      sda_low <= 1'h0;
      wr_en <= 1'h0;
    end else begin
      state <= next_state;
      after <= next_after;
      shift <= next_shift;
      pointer <= next_pointer;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      cnt <= next_cnt;
      full <= next_full;
      acked <= next_acked;
      sda_low <= next_sda_low;
      wr_en <= next_wr_en;
    end
  end

  // ========================================================================
  // Clock stretching and stuck-bus recovery
  logic stretch, next_stretch, waking, next_waking, released, next_released, sleep_req, next_sleep_req;
  logic owned, low_power, st_done;
  logic [`TMR_W-1:0] st_limit;
  assign owned = (state == ST_CMD) || (state == ST_WDATA) || (state == ST_RDATA) ||
                 (state == ST_ACK_OUT) || (state == ST_ACK_IN);
  assign low_power = (power_mode_in == MODE_SLEEP) || (power_mode_in == MODE_HIBERNATE);
  // Caps keep a hung core from holding the bus past its budget
  assign st_limit = waking ? WAKE_CYCLES : (nv_update_in ? NV_CYCLES : FLOW_CYCLES);

  gauge_hold_timer #(.W(`TMR_W)) stretch_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clear_in(!stretch),
    .limit_in(st_limit),
    .done_out(st_done)
  );

  gauge_hold_timer #(.W(`TMR_W)) stuck_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clear_in(lines_high),
    .limit_in(TIMEOUT_CYCLES),
    .done_out(to_done)
  );

  // Stretch begins on a falling SCL edge, while SCL is already low
  always_comb begin
    next_stretch = stretch;
    next_waking = waking;
    next_released = released;
    next_sleep_req = released && !lines_high;
    if (to_done) begin
      next_stretch = 1'h0;
      next_waking = 1'h0;
      next_released = 1'h1;
    end else begin
      if (lines_high) begin
        next_released = 1'h0;
      end
      if (start && low_power) begin
        next_waking = 1'h1;
      end
      if (stretch) begin
        if (st_done || !(waking || core_busy_in)) begin
          next_stretch = 1'h0;
          next_waking = 1'h0;
        end
      end else if (scl_fall && (waking || (core_busy_in && owned))) begin
        next_stretch = 1'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      stretch <= 1'h0;
      waking <= 1'h0;
      released <= 1'h0;
      sleep_req <= 1'h0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      stretch <= next_stretch;
      waking <= next_waking;
      released <= next_released;
      sleep_req <= next_sleep_req;
    end
  end

  // Open-drain: only ever pull low
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe_out = stretch;
  assign sda_oe_out = sda_low;
  assign cmd_addr_out = pointer;
  assign wr_addr_out = wr_addr;
  assign wr_data_out = wr_data;
  assign wr_en_out = wr_en;
  assign sleep_req_out = sleep_req;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_foreign_quiet: assert property (state == ST_IGNORE |-> !sda_oe_out)
    else $error("SDA driven during ignored transfer");
  chk_bad_cmd_nack: assert property (state == ST_CMD && scl_fall && full && shift > `CMD_MAX && !to_done
    |=> state == ST_IGNORE && !sda_oe_out)
    else $error("Command above limit was acknowledged");
  chk_ro_write_nack: assert property (state == ST_WDATA && scl_fall && full && !writable && !to_done
    |=> !wr_en_out && state == ST_IGNORE)
    else $error("Read-only write accepted");
  chk_ptr_advance: assert property (state == ST_ACK_IN && scl_rise && !sda_in && !to_done
    |=> cmd_addr_out == $past(cmd_addr_out) + `PTR_STEP)
    else $error("Pointer did not advance on host acknowledge");
  chk_timeout_release: assert property (to_done |=> !scl_oe_out && !sda_oe_out)
    else $error("Lines not released after timeout");
  chk_sleep_entry: assert property (released && !lines_high && !to_done |=> sleep_req_out)
    else $error("Sleep not requested with lines held low");
  chk_stretch_cap: assert property (scl_oe_out && st_done && !to_done |=> !scl_oe_out)
    else $error("Stretch outlived its limit");
  chk_quick_read_load: assert property (state == ST_ACK_OUT && scl_fall && after == ST_RDATA && !to_done
    |=> shift == $past(rd_data_in) && sda_oe_out == !$past(rd_data_in[7]))
    else $error("Read data not taken from pointer location");
  chk_no_foreign_stretch: assert property (state == ST_IGNORE && !waking && scl_fall
    |=> !$rose(scl_oe_out))
    else $error("Stretch on foreign packet");

  cov_write: cover property (wr_en_out);
  cov_read_ack: cover property (state == ST_ACK_IN && scl_rise && !sda_in);
  cov_wake_stretch: cover property (waking && scl_oe_out);
  cov_timeout: cover property (to_done);
endmodule
`default_nettype wire

// [testbench/gauge_host_model.sv]
// Bus controller model that drives the two-wire lines from the far side
`timescale 1ns/100ps
`default_nettype none
module gauge_host_model #(
  parameter int QTR = 34,
  parameter int GAP = 660
) (
  input wire logic core_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out,
  output logic hang_out
);
  // ==========================================================================
  // Line control
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    hang_out = 1'b0;
  end
  // Every change lands just after a core clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Release SCL and wait out any stretch, but never forever
  task automatic scl_up();
    int n;
    n = 0;
    scl_low_out = 1'b0;
    tick(1);
    while (scl_in !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    if (n >= 5000) hang_out = 1'b1;
  endtask
  // QTR of 34 cycles gives a bit of 103 cycles, near 97 kHz, so incremental writes stay legal
  task automatic put_bit(input logic b, output logic seen);
    sda_low_out = ~b;
    tick(QTR);
    scl_up();
    seen = sda_in;
    tick(QTR);
    scl_low_out = 1'b1;
    tick(QTR);
  endtask
  // ==========================================================================
  // Framing
  task automatic start();
    sda_low_out = 1'b1;
    tick(QTR);
    scl_low_out = 1'b1;
    tick(QTR);
  endtask
  // Bus stays free long enough before the next packet
  task automatic stop();
    sda_low_out = 1'b1;
    tick(QTR);
    scl_up();
    tick(QTR);
    sda_low_out = 1'b0;
    tick(GAP);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~ack, s);
  endtask
endmodule
`default_nettype wire

// [testbench/gauge_i2c_target_tb.sv]
// Self-checking bench for the two-wire target port
`timescale 1ns/100ps
`default_nettype none
module gauge_i2c_target_tb import gauge_i2c_pkg::*;;
  localparam int FLOW = 20;
  localparam int NV = 60;
  localparam int WAKE = 20;
  // Stuck-bus limit above the longest low run of a legal packet, about ten bits
  localparam int TMO = 2000;
  logic core_clk = 1'b0, rst = 1'b1, scl_oe, sda_oe, scl_low, sda_low, hang;
  logic scl_o, sda_o, agent_low = 1'b0;
  logic sealed = 1'b0, wr_sealed = 1'b0, wr_unsealed = 1'b1, busy = 1'b0, nv = 1'b0;
  logic wr_en, sleep_req, a0, a1, a2, sda_seen;
  logic [7:0] rd_data, cmd_addr, wr_addr, wr_data, last_wa, last_wd, d0, d1;
  mode_t mode = MODE_NORMAL;
  // Open drain: an enabled driver pulls low only when it drives a zero
  wire scl_w = ~(scl_low | (scl_oe & ~scl_o));
  wire sda_w = ~(sda_low | agent_low | (sda_oe & ~sda_o));
  int n_fail = 0, checks_done = 0, n_wr = 0, run = 0, max_run = 0;
  // Read data follows the pointer so every byte tells where it came from
  assign rd_data = cmd_addr ^ 8'hA5;
  always #50 core_clk = ~core_clk;
  gauge_i2c_target #(.TIMEOUT_CYCLES(25'(TMO)), .WAKE_CYCLES(25'(WAKE)), .FLOW_CYCLES(25'(FLOW)),
    .NV_CYCLES(25'(NV))) u_gauge_i2c_target (.core_clk_in(core_clk), .rst_in(rst), .scl_in(scl_w),
    .sda_in(sda_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .power_mode_in(mode), .sealed_in(sealed), .writable_sealed_in(wr_sealed),
    .writable_unsealed_in(wr_unsealed), .core_busy_in(busy), .nv_update_in(nv), .rd_data_in(rd_data),
    .cmd_addr_out(cmd_addr), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_en_out(wr_en),
    .sleep_req_out(sleep_req));
  gauge_host_model u_gauge_host_model (.core_clk_in(core_clk), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(scl_low), .sda_low_out(sda_low), .hang_out(hang));
  // ==========================================================================
  // Monitors: write strobes, longest stretch, any target drive of SDA
  always @(posedge core_clk) begin
    if (wr_en) begin
      n_wr <= n_wr + 1;
      last_wa <= wr_addr;
      last_wd <= wr_data;
    end
    run <= scl_oe ? run + 1 : 0;
    if (scl_oe && run + 1 > max_run) max_run <= run + 1;
    if (sda_oe) sda_seen <= 1'b1;
    if (hang) summarize();
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    if (hang) n_fail++;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pkt_write(input logic [7:0] cmd, input logic [7:0] dat);
    max_run = 0;
    u_gauge_host_model.start();
    u_gauge_host_model.wbyte(8'hAA, a0);
    u_gauge_host_model.wbyte(cmd, a1);
    u_gauge_host_model.wbyte(dat, a2);
    u_gauge_host_model.stop();
  endtask
  // ==========================================================================
  // Scenarios
  // Written value is judged at the strobe, never read back as an updated result
  task automatic s_write();
    pkt_write(8'h02, 8'h5A);
    check("acks", 32'h7, {29'h0, a0, a1, a2});
    check("writes", 32'h1, n_wr);
    check("wr addr", 32'h02, last_wa);
    check("wr data", 32'h5A, last_wd);
    check("pointer", 32'h03, cmd_addr);
  endtask
  // Sealed mode with a location writable only when unsealed
  task automatic s_read_only();
    sealed = 1'b1;
    pkt_write(8'h04, 8'h33);
    check("ro data ack", 32'h0, a2);
    check("ro writes", 32'h1, n_wr);
    sealed = 1'b0;
  endtask
  task automatic s_limit();
    pkt_write(8'h6C, 8'h00);
    check("cmd 6C ack", 32'h0, a1);
    pkt_write(8'h6B, 8'h11);
    check("cmd 6B ack", 32'h1, a1);
    check("6B addr", 32'h6B, last_wa);
  endtask
  task automatic s_read();
    u_gauge_host_model.start();
    u_gauge_host_model.wbyte(8'hAA, a0);
    u_gauge_host_model.wbyte(8'h10, a1);
    u_gauge_host_model.stop();
    u_gauge_host_model.start();
    u_gauge_host_model.wbyte(8'hAB, a2);
    u_gauge_host_model.rbyte(1'b1, d0);
    u_gauge_host_model.rbyte(1'b0, d1);
    u_gauge_host_model.stop();
    check("rd ack", 32'h1, a2);
    check("rd byte0", 32'h10 ^ 32'hA5, d0);
    check("rd byte1", 32'h11 ^ 32'hA5, d1);
    check("rd pointer", 32'h11, cmd_addr);
    u_gauge_host_model.start();
    u_gauge_host_model.wbyte(8'hAB, a2);
    u_gauge_host_model.rbyte(1'b0, d0);
    u_gauge_host_model.stop();
    check("quick read", 32'h11 ^ 32'hA5, d0);
  endtask
  // Foreign address with the core busy: no answer, and no stretch except the wake stretch in sleep and hibernate
  task automatic s_foreign(input mode_t m, input int exp_lo, input int exp_hi);
    mode = m;
    busy = 1'b1;
    sda_seen = 1'b0;
    max_run = 0;
    u_gauge_host_model.start();
    u_gauge_host_model.wbyte(8'h44, a0);
    u_gauge_host_model.wbyte(8'h00, a1);
    u_gauge_host_model.stop();
    check("foreign ack", 32'h0, a0);
    check("foreign sda", 32'h0, sda_seen);
    check("foreign stretch", 32'h1, 32'(max_run >= exp_lo && max_run <= exp_hi));
    mode = MODE_NORMAL;
    busy = 1'b0;
  endtask
  task automatic s_stretch(input logic nv_on, input int cap);
    busy = 1'b1;
    nv = nv_on;
    pkt_write(8'h02, 8'h01);
    check("stretch len", 32'h1, 32'(max_run >= cap - 1 && max_run <= cap + 2));
    check("stretch acks", 32'h7, {29'h0, a0, a1, a2});
    busy = 1'b0;
    nv = 1'b0;
  endtask
  // Outside agent holds SDA low past the stuck-bus limit
  task automatic s_timeout();
    agent_low = 1'b1;
    u_gauge_host_model.tick(TMO + 15);
    check("tmo release", 32'h0, {30'h0, scl_oe, sda_oe});
    check("tmo sleep", 32'h1, sleep_req);
    agent_low = 1'b0;
    u_gauge_host_model.tick(3);
    check("tmo wake", 32'h0, sleep_req);
    u_gauge_host_model.tick(20);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    u_gauge_host_model.tick(2);
    check("reset ptr", 32'h0, cmd_addr);
    s_write();
    s_read_only();
    s_limit();
    s_read();
    s_foreign(MODE_NORMAL, 0, 0);
    s_foreign(MODE_BATTERY_PRESENCE_WAIT, 0, 0);
    s_foreign(MODE_SLEEP, WAKE - 1, WAKE + 2);
    s_foreign(MODE_HIBERNATE, WAKE - 1, WAKE + 2);
    s_stretch(1'b0, FLOW);
    s_stretch(1'b1, NV);
    s_timeout();
    summarize();
  end
endmodule
`default_nettype wire
